// ### hdl/coag_defs.vh
// constants for the operand address generator
`ifndef COAG_DEFS_VH
`define COAG_DEFS_VH
// ==========================================
// addressing mode codes (17 modes, 5-bit field)
`define COAG_M_INH      5'h00
`define COAG_M_IMM      5'h01
`define COAG_M_DIR_S    5'h02
`define COAG_M_DIR_L    5'h03
`define COAG_M_IDX_0    5'h04
`define COAG_M_IDX_S    5'h05
`define COAG_M_IDX_L    5'h06
`define COAG_M_IND_S    5'h07
`define COAG_M_IND_L    5'h08
`define COAG_M_IIX_S    5'h09
`define COAG_M_IIX_L    5'h0a
`define COAG_M_REL_D    5'h0b
`define COAG_M_REL_I    5'h0c
`define COAG_M_BIT_D    5'h0d
`define COAG_M_BIT_I    5'h0e
`define COAG_M_BTJ_D    5'h0f
`define COAG_M_BTJ_I    5'h10
`define COAG_MODE_COUNT 5'h11
// ==========================================
// instruction classes
`define COAG_C_OTHER    3'h0
`define COAG_C_RMW      3'h1
`define COAG_C_JREL     3'h2
`define COAG_C_REL_CALL 3'h3
`define COAG_C_MASK     3'h4
`define COAG_C_UNMASK   3'h5
// ==========================================
// interrupt mask levels and reset values
`define COAG_IMASK_SET  2'h3
`define COAG_IMASK_NONE 2'h0
`define COAG_IMASK_RST  2'h3
`define COAG_ADDR_RST   16'h0000
`endif

// ### hdl/coag_len.v
// operand length and short-form legality per addressing mode
`timescale 1ns/1ps
`include "coag_defs.vh"
module coag_len (
   input  wire [4:0] mode_i,
   input  wire [2:0] iclass_i,
   output reg  [1:0] len_o,
   output reg        short_o,
   output reg        legal_o
);
   always @* begin
      len_o   = 2'h0;
      short_o = 1'b1;
      case (mode_i)
         `COAG_M_INH   : len_o = 2'h0;
         `COAG_M_IMM   : len_o = 2'h1;
         `COAG_M_DIR_S : len_o = 2'h1;
         `COAG_M_DIR_L : begin
            len_o   = 2'h2;
            short_o = 1'b0;
         end
         `COAG_M_IDX_0 : len_o = 2'h0;
         `COAG_M_IDX_S : len_o = 2'h1;
         `COAG_M_IDX_L : begin
            len_o   = 2'h2;
            short_o = 1'b0;
         end
         `COAG_M_IND_S : len_o = 2'h1;
         `COAG_M_IND_L : begin
            len_o   = 2'h1;
            short_o = 1'b0;
         end
         `COAG_M_IIX_S : len_o = 2'h1;
         `COAG_M_IIX_L : begin
            len_o   = 2'h1;
            short_o = 1'b0;
         end
         `COAG_M_REL_D : len_o = 2'h1;
         `COAG_M_REL_I : len_o = 2'h1;
         `COAG_M_BIT_D : len_o = 2'h1;
         `COAG_M_BIT_I : len_o = 2'h1;
         `COAG_M_BTJ_D : len_o = 2'h2;
         `COAG_M_BTJ_I : len_o = 2'h2;
         default       : len_o = 2'h0;
      endcase
   end
   // relative modes only for jumps and relative call; memory rmw only in short form
   always @* begin
      legal_o = (mode_i < `COAG_MODE_COUNT);
      if ((mode_i == `COAG_M_REL_D) || (mode_i == `COAG_M_REL_I))
         legal_o = legal_o & ((iclass_i == `COAG_C_JREL) | (iclass_i == `COAG_C_REL_CALL));
      if ((iclass_i == `COAG_C_RMW) && !short_o)
         legal_o = 1'b0;
   end
endmodule

// ### hdl/coag_ptr.v
// pointer byte register: holds bytes read from page zero
`timescale 1ns/1ps
module coag_ptr (
   input  wire       clk_i,
   input  wire       rst_n_i,
   input  wire       wr_hi_i,
   input  wire       wr_lo_i,
   input  wire [7:0] data_i,
   output reg  [15:0] ptr_o
);
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ptr_o <= 16'h0000;
      end else begin
         if (wr_hi_i)
            ptr_o[15:8] <= data_i;
         if (wr_lo_i)
            ptr_o[7:0] <= data_i;
      end
   end
endmodule

// ### hdl/coag_top.v
// operand address generator: fetches operand bytes and forms effective address
// Notes on behaviour
// - seventeen addressing modes are decoded; other codes are refused.
// - inherent instructions are one byte, no operand bytes fetched.
// - immediate fetches one byte, used directly as operand value.
// - short direct fetches one address byte, page zero only.
// - long direct fetches a two-byte address, full space.
// - indexed address is unsigned index register plus offset.
// - no-offset indexed fetches nothing, address is index register.
// - short indexed fetches one offset byte, sum reaches 1fe.
// - long indexed fetches two offset bytes plus index, full space.
// - short indirect reads one-byte pointer from page zero.
// - long indirect reads two-byte pointer from page zero.
// - indirect indexed adds index register to pointer read from memory.
// - short form byte pointer reaches 1fe; long form uses word pointer.
// - relative adds signed 8-bit offset to program counter.
// - relative direct offset follows opcode; indirect reads offset in page zero.
// - relative modes allowed only for conditional jumps and relative call.
// - read-modify-write memory instructions accept short forms only.
// - mask instruction sets level 3, unmask instruction sets level 0, in inherent and no-offset forms only.
`timescale 1ns/1ps
`include "coag_defs.vh"
module coag_top (
   input  wire        CLK_SYS_I,
   input  wire        RST_N_I,
   input  wire        START_I,
   input  wire [4:0]  MODE_I,
   input  wire [2:0]  ICLASS_I,
   input  wire        USE_Y_I,
   input  wire [7:0]  X_I,
   input  wire [7:0]  Y_I,
   input  wire [15:0] PC_I,
   output wire        BUSY_O,
   output reg         MEM_RD_O,
   output reg  [15:0] MEM_ADDR_O,
   input  wire [7:0]  MEM_DATA_I,
   input  wire        MEM_ACK_I,
   output reg         DONE_O,
   output reg         ERR_O,
   output reg  [15:0] EA_O,
   output reg  [7:0]  IMM_O,
   output reg         IMM_VALID_O,
   output reg  [15:0] TARGET_O,
   output reg         TARGET_VALID_O,
   output reg  [1:0]  LEN_O,
   output reg  [1:0]  IMASK_O
);
   // ==========================================
   // states
   localparam [5:0] S_IDLE = 6'h01;
   localparam [5:0] S_OP   = 6'h02;
   localparam [5:0] S_PTR  = 6'h04;
   localparam [5:0] S_REL  = 6'h08;
   localparam [5:0] S_CALC = 6'h10;
   localparam [5:0] S_DONE = 6'h20;

   // ==========================================
   // functions
   // unsigned index sum kept at full width so short forms reach 1fe
   function [15:0] idx_add;
      input [15:0] base;
      input [7:0]  idx;
      begin
         idx_add = base + {8'h00, idx};
      end
   endfunction

   function [15:0] rel_add;
      input [15:0] pc;
      input [7:0]  off;
      begin
         rel_add = pc + {{8{off[7]}}, off};
      end
   endfunction

   // page-zero address from one byte
   function [15:0] pz_addr;
      input [7:0] lo;
      begin
         pz_addr = {8'h00, lo};
      end
   endfunction

   // operand bytes that carry an address or pointer address; any further byte is an offset
   function [1:0] addr_len;
      input [4:0] mode;
      begin
         case (mode)
            `COAG_M_INH, `COAG_M_IDX_0, `COAG_M_REL_D : addr_len = 2'h0;
            `COAG_M_DIR_L, `COAG_M_IDX_L              : addr_len = 2'h2;
            default                                   : addr_len = 2'h1;
         endcase
      end
   endfunction

   // ==========================================
   // registers
   reg [5:0]  state_q;
   reg [4:0]  mode_q;
   reg [2:0]  iclass_q;
   reg [7:0]  idx_q;
   reg [15:0] pc_q;
   reg [15:0] opw_q;
   reg [1:0]  cnt_q;
   reg [1:0]  need_q;
   reg [1:0]  pcnt_q;
   reg [15:0] ptr_addr_q;
   reg [7:0]  rel_off_q;

   wire [1:0]  len_w;
   wire        short_w;
   wire        legal_w;
   wire [15:0] ptr_w;
   reg         ptr_hi_we;
   reg         ptr_lo_we;

   coag_len u_len (
      .mode_i   (MODE_I),
      .iclass_i (ICLASS_I),
      .len_o    (len_w),
      .short_o  (short_w),
      .legal_o  (legal_w)
   );

   coag_ptr u_ptr (
      .clk_i   (CLK_SYS_I),
      .rst_n_i (RST_N_I),
      .wr_hi_i (ptr_hi_we),
      .wr_lo_i (ptr_lo_we),
      .data_i  (MEM_DATA_I),
      .ptr_o   (ptr_w)
   );

   assign BUSY_O = ~state_q[0];

   // ==========================================
   // mode properties
   wire is_word_ptr = (mode_q == `COAG_M_IND_L) | (mode_q == `COAG_M_IIX_L);
   wire is_ind = (mode_q == `COAG_M_IND_S) | (mode_q == `COAG_M_IND_L) |
                 (mode_q == `COAG_M_IIX_S) | (mode_q == `COAG_M_IIX_L) |
                 (mode_q == `COAG_M_REL_I) | (mode_q == `COAG_M_BIT_I) |
                 (mode_q == `COAG_M_BTJ_I);
   // first operand byte is always the page-zero pointer address in indirect forms
   wire [1:0] addr_bytes = addr_len(mode_q);

   // pointer register high and low byte write strobes
   always @* begin
      ptr_hi_we = 1'b0;
      ptr_lo_we = 1'b0;
      if (state_q == S_PTR && MEM_ACK_I) begin
         if (is_word_ptr && pcnt_q == 2'h0)
            ptr_hi_we = 1'b1;
         else
            ptr_lo_we = 1'b1;
      end
   end

   // ==========================================
   // sequencer
   always @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         state_q        <= S_IDLE;
         mode_q         <= `COAG_M_INH;
         iclass_q       <= `COAG_C_OTHER;
         idx_q          <= 8'h00;
         pc_q           <= `COAG_ADDR_RST;
         opw_q          <= 16'h0000;
         cnt_q          <= 2'h0;
         need_q         <= 2'h0;
         pcnt_q         <= 2'h0;
         ptr_addr_q     <= 16'h0000;
         rel_off_q      <= 8'h00;
         MEM_RD_O       <= 1'b0;
         MEM_ADDR_O     <= `COAG_ADDR_RST;
         DONE_O         <= 1'b0;
         ERR_O          <= 1'b0;
         EA_O           <= `COAG_ADDR_RST;
         IMM_O          <= 8'h00;
         IMM_VALID_O    <= 1'b0;
         TARGET_O       <= `COAG_ADDR_RST;
         TARGET_VALID_O <= 1'b0;
         LEN_O          <= 2'h0;
         IMASK_O        <= `COAG_IMASK_RST;
      end else begin
         DONE_O <= 1'b0;
         case (state_q)
            S_IDLE: begin
               if (START_I) begin
                  mode_q         <= MODE_I;
                  iclass_q       <= ICLASS_I;
                  idx_q          <= USE_Y_I ? Y_I : X_I;
                  pc_q           <= PC_I;
                  opw_q          <= 16'h0000;
                  cnt_q          <= 2'h0;
                  pcnt_q         <= 2'h0;
                  need_q         <= len_w;
                  LEN_O          <= len_w;
                  ERR_O          <= 1'b0;
                  IMM_VALID_O    <= 1'b0;
                  TARGET_VALID_O <= 1'b0;
                  if (!legal_w) begin
                     ERR_O   <= 1'b1;
                     state_q <= S_DONE;
                  end else if (len_w == 2'h0) begin
                     // inherent and no-offset forms need no operand fetch
                     state_q <= S_CALC;
                     if (ICLASS_I == `COAG_C_MASK)
                        IMASK_O <= `COAG_IMASK_SET;
                     else if (ICLASS_I == `COAG_C_UNMASK)
                        IMASK_O <= `COAG_IMASK_NONE;
                  end else begin
                     MEM_RD_O   <= 1'b1;
                     MEM_ADDR_O <= PC_I + 16'h0001;
                     state_q    <= S_OP;
                  end
               end
            end
            S_OP: begin
               if (MEM_ACK_I) begin
                  // operand bytes arrive high byte first for word forms
                  // relative direct has no address bytes, its single byte is the offset
                  if (cnt_q < addr_bytes)
                     opw_q <= {opw_q[7:0], MEM_DATA_I};
                  else
                     rel_off_q <= MEM_DATA_I;
                  cnt_q <= cnt_q + 2'h1;
                  if (cnt_q + 2'h1 == need_q) begin
                     if (is_ind) begin
                        MEM_ADDR_O <= pz_addr((cnt_q == 2'h0) ? MEM_DATA_I : opw_q[7:0]);
                        ptr_addr_q <= pz_addr((cnt_q == 2'h0) ? MEM_DATA_I : opw_q[7:0]);
                        state_q    <= S_PTR;
                     end else begin
                        MEM_RD_O <= 1'b0;
                        state_q  <= S_CALC;
                     end
                  end else begin
                     MEM_ADDR_O <= MEM_ADDR_O + 16'h0001;
                  end
               end
            end
            S_PTR: begin
               if (MEM_ACK_I) begin
                  pcnt_q <= pcnt_q + 2'h1;
                  if (is_word_ptr && pcnt_q == 2'h0) begin
                     // word pointer: second byte at next page-zero location
                     MEM_ADDR_O <= {8'h00, ptr_addr_q[7:0] + 8'h01};
                  end else begin
                     MEM_RD_O <= 1'b0;
                     state_q  <= (mode_q == `COAG_M_REL_I) ? S_REL : S_CALC;
                  end
               end
            end
            S_REL: begin
               // the page-zero byte just read is the branch offset
               rel_off_q <= ptr_w[7:0];
               state_q   <= S_CALC;
            end
            S_CALC: begin
               state_q <= S_DONE;
               case (mode_q)
                  `COAG_M_INH   : EA_O <= 16'h0000;
                  `COAG_M_IMM   : begin
                     IMM_O       <= opw_q[7:0];
                     IMM_VALID_O <= 1'b1;
                  end
                  `COAG_M_DIR_S : EA_O <= {8'h00, opw_q[7:0]};
                  `COAG_M_DIR_L : EA_O <= opw_q;
                  `COAG_M_IDX_0 : EA_O <= {8'h00, idx_q};
                  `COAG_M_IDX_S : EA_O <= idx_add({8'h00, opw_q[7:0]}, idx_q);
                  `COAG_M_IDX_L : EA_O <= idx_add(opw_q, idx_q);
                  `COAG_M_IND_S : EA_O <= {8'h00, ptr_w[7:0]};
                  `COAG_M_IND_L : EA_O <= ptr_w;
                  `COAG_M_IIX_S : EA_O <= idx_add({8'h00, ptr_w[7:0]}, idx_q);
                  `COAG_M_IIX_L : EA_O <= idx_add(ptr_w, idx_q);
                  `COAG_M_REL_D, `COAG_M_REL_I : begin
                     // target relative to the address after the instruction
                     TARGET_O <= rel_add(pc_q + {14'h0000, need_q} + 16'h0001,
                                         rel_off_q);
                     TARGET_VALID_O <= 1'b1;
                  end
                  `COAG_M_BIT_D : EA_O <= {8'h00, opw_q[7:0]};
                  `COAG_M_BIT_I : EA_O <= {8'h00, ptr_w[7:0]};
                  `COAG_M_BTJ_D, `COAG_M_BTJ_I : begin
                     EA_O <= (mode_q == `COAG_M_BTJ_D) ? {8'h00, opw_q[7:0]} :
                             {8'h00, ptr_w[7:0]};
                     TARGET_O <= rel_add(pc_q + {14'h0000, need_q} + 16'h0001,
                                         rel_off_q);
                     TARGET_VALID_O <= 1'b1;
                  end
                  default : EA_O <= 16'h0000;
               endcase
            end
            S_DONE: begin
               DONE_O  <= 1'b1;
               state_q <= S_IDLE;
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end
endmodule

// ### test/coag_mem_model.sv
// program and data memory model answering the generator's byte reads
`timescale 1ns/1ps
module coag_mem_model (
   input  wire        clk_i,
   input  wire        rst_n_i,
   input  wire        rd_i,
   input  wire [15:0] addr_i,
   input  wire [1:0]  wait_i,
   output reg  [7:0]  data_o,
   output reg         ack_o
);
   reg [1:0] cnt_q;
   // =====
   // content is a fixed mix of the address bytes
   function automatic [7:0] mem_byte(input [15:0] a);
      mem_byte = a[7:0] ^ a[15:8] ^ 8'h5a;
   endfunction
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_q <= 2'h0;
         ack_o <= 1'b0;
         data_o <= 8'h00;
      end else if (rd_i && !ack_o && cnt_q == wait_i) begin
         cnt_q <= 2'h0;
         ack_o <= 1'b1;
         data_o <= mem_byte(addr_i);
      end else begin
         cnt_q <= (rd_i && !ack_o) ? cnt_q + 2'h1 : 2'h0;
         ack_o <= 1'b0;
         // released bus toggles every cycle, so a sample one cycle late sees the inverted byte
         data_o <= ~data_o;
      end
   end
endmodule

// ### test/coag_top_props.sv
// concurrent checks on the operand address generator ports
`timescale 1ns/1ps
`include "coag_defs.vh"
module coag_top_props (
   input wire        CLK_SYS_I,
   input wire        RST_N_I,
   input wire        START_I,
   input wire [4:0]  MODE_I,
   input wire [2:0]  ICLASS_I,
   input wire        USE_Y_I,
   input wire [7:0]  X_I,
   input wire [15:0] PC_I,
   input wire        BUSY_O,
   input wire        MEM_RD_O,
   input wire [15:0] MEM_ADDR_O,
   input wire        DONE_O,
   input wire        ERR_O,
   input wire [15:0] EA_O,
   input wire [1:0]  IMASK_O
);
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (!RST_N_I);
   wire tk = START_I && !BUSY_O;
   // =====
   // length-0 request: no read, done on the third edge
   sequence s_quiet;
      ##1 (!MEM_RD_O)[*2] ##1 DONE_O;
   endsequence
   sequence s_refuse;
      ##1 !MEM_RD_O ##1 (DONE_O && ERR_O);
   endsequence
   property p_inh;
      tk && MODE_I == `COAG_M_INH |-> s_quiet;
   endproperty
   a_inh: assert property (p_inh) else $error("inherent op read memory");
   property p_idx0;
      tk && MODE_I == `COAG_M_IDX_0 && ICLASS_I == `COAG_C_OTHER && !USE_Y_I
         |-> s_quiet ##0 EA_O == {8'h00, $past(X_I, 3)};
   endproperty
   a_idx0: assert property (p_idx0) else $error("no-offset index address wrong");
   property p_ill;
      tk && MODE_I >= `COAG_MODE_COUNT |-> s_refuse;
   endproperty
   a_ill: assert property (p_ill) else $error("unknown mode not refused");
   property p_rmw;
      tk && ICLASS_I == `COAG_C_RMW && MODE_I == `COAG_M_DIR_L |-> s_refuse;
   endproperty
   a_rmw: assert property (p_rmw) else $error("long form accepted for rmw");
   property p_rel;
      tk && (MODE_I == `COAG_M_REL_D || MODE_I == `COAG_M_REL_I)
         && ICLASS_I == `COAG_C_OTHER |-> s_refuse;
   endproperty
   a_rel: assert property (p_rel) else $error("relative mode on wrong class");
   property p_mask;
      tk && MODE_I == `COAG_M_INH && ICLASS_I == `COAG_C_MASK |-> ##3 IMASK_O == 2'h3;
   endproperty
   a_mask: assert property (p_mask) else $error("mask level not 3");
   property p_unmask;
      tk && MODE_I == `COAG_M_INH && ICLASS_I == `COAG_C_UNMASK |-> ##3 IMASK_O == 2'h0;
   endproperty
   a_unmask: assert property (p_unmask) else $error("mask level not 0");
   property p_first;
      tk && MODE_I == `COAG_M_DIR_S && ICLASS_I == `COAG_C_OTHER
         |=> MEM_RD_O && MEM_ADDR_O == $past(PC_I) + 16'h0001;
   endproperty
   a_first: assert property (p_first) else $error("address byte not at pc+1");
endmodule
bind coag_top coag_top_props u_props (.CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I),
   .START_I(START_I), .MODE_I(MODE_I), .ICLASS_I(ICLASS_I), .USE_Y_I(USE_Y_I),
   .X_I(X_I), .PC_I(PC_I), .BUSY_O(BUSY_O), .MEM_RD_O(MEM_RD_O), .MEM_ADDR_O(MEM_ADDR_O),
   .DONE_O(DONE_O), .ERR_O(ERR_O), .EA_O(EA_O), .IMASK_O(IMASK_O));

// ### test/tb_coag_top.sv
// self-checking bench for the operand address generator
`timescale 1ns/1ps
`include "coag_defs.vh"
module tb_coag_top;
   reg         CLK_SYS_I, RST_N_I, START_I, USE_Y_I;
   reg  [4:0]  MODE_I;
   reg  [2:0]  ICLASS_I;
   reg  [7:0]  X_I, Y_I;
   reg  [15:0] PC_I;
   reg  [1:0]  mem_wait;
   wire        BUSY_O, MEM_RD_O, MEM_ACK_I, DONE_O, ERR_O, IMM_VALID_O, TARGET_VALID_O;
   wire [15:0] MEM_ADDR_O, EA_O, TARGET_O;
   wire [7:0]  MEM_DATA_I, IMM_O;
   wire [1:0]  LEN_O, IMASK_O;
   integer     fails, comparisons, acks;
   coag_top u_dut (.CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I), .START_I(START_I),
      .MODE_I(MODE_I), .ICLASS_I(ICLASS_I), .USE_Y_I(USE_Y_I), .X_I(X_I), .Y_I(Y_I),
      .PC_I(PC_I), .BUSY_O(BUSY_O), .MEM_RD_O(MEM_RD_O), .MEM_ADDR_O(MEM_ADDR_O),
      .MEM_DATA_I(MEM_DATA_I), .MEM_ACK_I(MEM_ACK_I), .DONE_O(DONE_O), .ERR_O(ERR_O),
      .EA_O(EA_O), .IMM_O(IMM_O), .IMM_VALID_O(IMM_VALID_O), .TARGET_O(TARGET_O),
      .TARGET_VALID_O(TARGET_VALID_O), .LEN_O(LEN_O), .IMASK_O(IMASK_O));
   coag_mem_model u_mem (.clk_i(CLK_SYS_I), .rst_n_i(RST_N_I), .rd_i(MEM_RD_O),
      .addr_i(MEM_ADDR_O), .wait_i(mem_wait), .data_o(MEM_DATA_I), .ack_o(MEM_ACK_I));
   // =====
   // helpers
   initial begin
      CLK_SYS_I = 1'b0;
      forever #12.5 CLK_SYS_I = ~CLK_SYS_I;
   end
   always @(posedge CLK_SYS_I) if (MEM_ACK_I === 1'b1) acks = acks + 1;
   function [7:0] mb(input [15:0] a);
      mb = u_mem.mem_byte(a);
   endfunction
   task chk(input [15:0] got, input [15:0] exp);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            fails = fails + 1;
            $display("[FAIL] %0t mode %h got %h expected %h", $time, MODE_I, got, exp);
         end
      end
   endtask
   task wait_done;
      integer n;
      begin
         n = 0;
         while (DONE_O !== 1'b1 && n < 40) begin
            @(posedge CLK_SYS_I);
            #1 n = n + 1;
         end
         chk(16'(DONE_O), 16'h1);
      end
   endtask
   task run(input [4:0] m, input [2:0] c, input [15:0] pc);
      begin
         MODE_I = m;
         ICLASS_I = c;
         PC_I = pc;
         acks = 0;
         START_I = 1'b1;
         @(posedge CLK_SYS_I);
         #1 START_I = 1'b0;
         wait_done;
      end
   endtask
   task end_sim;
      begin
         $display("comparisons %0d fails %0d", comparisons, fails);
         if (fails == 0 && comparisons > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   // =====
   // scenarios
   task t_mask;
      begin
         chk(16'(IMASK_O), 16'(`COAG_IMASK_RST));
         run(`COAG_M_INH, `COAG_C_UNMASK, 16'h1000);
         chk(16'(IMASK_O), 16'(`COAG_IMASK_NONE));
         chk(16'(acks), 16'h0);
         chk(16'(LEN_O), 16'h0);
         run(`COAG_M_INH, `COAG_C_MASK, 16'h1000);
         chk(16'(IMASK_O), 16'(`COAG_IMASK_SET));
         $display("test mask finished");
      end
   endtask
   task t_direct;
      begin
         run(`COAG_M_IMM, `COAG_C_OTHER, 16'h2000);
         chk({IMM_VALID_O, 5'h00, LEN_O, IMM_O}, {8'h81, mb(16'h2001)});
         run(`COAG_M_DIR_S, `COAG_C_OTHER, 16'h2000);
         chk(EA_O, {8'h00, mb(16'h2001)});
         mem_wait = 2'h2;
         run(`COAG_M_DIR_L, `COAG_C_OTHER, 16'h2000);
         chk(EA_O, {mb(16'h2001), mb(16'h2002)});
         chk(16'(acks), 16'h2);
         mem_wait = 2'h0;
         $display("test direct finished");
      end
   endtask
   task t_index;
      reg [7:0] p;
      begin
         run(`COAG_M_IDX_0, `COAG_C_OTHER, 16'h1000);
         chk(EA_O, {8'h00, X_I});
         chk(16'(acks), 16'h0);
         run(`COAG_M_IDX_S, `COAG_C_OTHER, 16'h00a4);
         chk(EA_O, {8'h00, mb(16'h00a5)} + 16'h00ff);
         run(`COAG_M_IDX_L, `COAG_C_OTHER, 16'h2000);
         chk(EA_O, {mb(16'h2001), mb(16'h2002)} + 16'h00ff);
         p = mb(16'h2001);
         run(`COAG_M_IND_S, `COAG_C_OTHER, 16'h2000);
         chk(EA_O, {8'h00, mb({8'h00, p})});
         chk(16'(acks), 16'h2);
         run(`COAG_M_IND_L, `COAG_C_OTHER, 16'h00a4);
         chk(EA_O, {mb(16'h00ff), mb(16'h0000)});
         USE_Y_I = 1'b1;
         run(`COAG_M_IIX_S, `COAG_C_OTHER, 16'h2000);
         chk(EA_O, {8'h00, mb({8'h00, p})} + 16'h0080);
         run(`COAG_M_IIX_L, `COAG_C_OTHER, 16'h2000);
         chk(EA_O, {mb({8'h00, p}), mb({8'h00, p + 8'h01})} + 16'h0080);
         USE_Y_I = 1'b0;
         $display("test index finished");
      end
   endtask
   task t_rel;
      reg [7:0] o;
      begin
         o = mb(16'h00a5);
         run(`COAG_M_REL_D, `COAG_C_JREL, 16'h00a4);
         chk(TARGET_O, 16'h00a6 + {{8{o[7]}}, o});
         o = mb(16'h2001);
         run(`COAG_M_REL_D, `COAG_C_REL_CALL, 16'h2000);
         chk(TARGET_O, 16'h2002 + {{8{o[7]}}, o});
         o = mb({8'h00, mb(16'h2001)});
         run(`COAG_M_REL_I, `COAG_C_JREL, 16'h2000);
         chk({TARGET_VALID_O, ERR_O}, 2'h2);
         chk(TARGET_O, 16'h2002 + {{8{o[7]}}, o});
         run(`COAG_M_DIR_S, `COAG_C_RMW, 16'h2000);
         chk(16'(ERR_O), 16'h0);
         run(`COAG_M_DIR_L, `COAG_C_RMW, 16'h2000);
         chk(16'(ERR_O), 16'h1);
         chk(16'(acks), 16'h0);
         $display("test relative finished");
      end
   endtask
   task t_modes;
      integer m;
      begin
         for (m = 0; m < 18; m = m + 1) begin
            run(m[4:0], `COAG_C_OTHER, 16'h2000);
            chk(16'(ERR_O), 16'(m == 11 || m == 12 || m == 17));
         end
         $display("test modes finished");
      end
   endtask
   task t_busy;
      begin
         run(`COAG_M_INH, `COAG_C_UNMASK, 16'h1000);
         mem_wait = 2'h3;
         MODE_I = `COAG_M_DIR_L;
         PC_I = 16'h2000;
         START_I = 1'b1;
         @(posedge CLK_SYS_I);
         #1 MODE_I = `COAG_M_INH;
         ICLASS_I = `COAG_C_MASK;
         chk({14'h0000, BUSY_O, MEM_RD_O}, 16'h0003);
         chk(MEM_ADDR_O, 16'h2001);
         repeat (2) @(posedge CLK_SYS_I);
         #1 START_I = 1'b0;
         wait_done;
         chk(16'(IMASK_O), 16'(`COAG_IMASK_NONE));
         chk(EA_O, {mb(16'h2001), mb(16'h2002)});
         $display("test busy finished");
      end
   endtask
   // =====
   // main sequence and watchdog
   initial begin
      {RST_N_I, START_I, USE_Y_I, MODE_I, ICLASS_I, PC_I, mem_wait} = 0;
      X_I = 8'hff;
      Y_I = 8'h80;
      fails = 0;
      comparisons = 0;
      acks = 0;
      repeat (3) @(posedge CLK_SYS_I);
      #1 RST_N_I = 1'b1;
      t_mask;
      t_direct;
      t_index;
      t_rel;
      t_modes;
      t_busy;
      end_sim;
   end
   initial begin
      repeat (3000) @(posedge CLK_SYS_I);
      fails = fails + 1;
      end_sim;
   end
endmodule
